// ### dv/tb.sv
// self-checking bench for the serial status and control block
`timescale 1ns/100ps
`include "usc_params.svh"
module tb;
  localparam logic [7:0] ST = `USC_OFS_STA, MD = `USC_OFS_MODE, TD = `USC_OFS_TXD, RD = `USC_OFS_RXD;
  localparam logic [31:0] NO = 32'h0000_0000, AL = 32'hFFFF_FFFF, B8 = 32'h0000_01FF;
  logic rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, stall = 1'b0;
  logic rxActive = 1'b0, rxCharValid = 1'b0, rxParErr = 1'b0, rxFrmErr = 1'b0, rx_pin = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, m;
  logic [8:0] rxChar = 9'h000, txChar;
  logic sys_clk, wb_ack_o, txCharValid, txCharTake, txBusy, txBitRaw, txBreakReq, txBreakDone, txAbort;
  logic tx_pin_o, tx_pin_oe, rxLine, rxPinOwned, rxHold, rxFlush, txIrq, rxIrq, irEnable;
  logic [1:0] parDataSel;
  logic [31:0] expQ[$], mskQ[$];
  logic [8:0] txQ[$];
  logic [8:0] adrSeq[4] = '{9'h033, 9'h15B, 9'h15A, 9'h077};
  int miscompares = 0, checks_done = 0, i;
  usc_status_control #(.DEPTH(8)) i_dut (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .txCharValid, .txChar, .txCharTake, .txBusy,
    .txBitRaw, .irEncBit(1'b0), .txBreakReq, .txBreakDone, .txAbort, .tx_pin_o, .tx_pin_oe, .rx_pin,
    .rxLine, .rxPinOwned, .rxActive, .rxCharValid, .rxChar, .rxParErr, .rxFrmErr, .rxHold, .rxFlush,
    .txIrq, .rxIrq, .irEnable, .parDataSel);
  usc_engine_model i_eng (.sys_clk, .rst_n, .stall, .txCharValid, .txBreakReq, .txAbort, .txCharTake,
    .txBusy, .txBitRaw, .txBreakDone);
  // ==========================================
  // clock, random line noise and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) rx_pin <= 1'($urandom);
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end
  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  // classic cycle; a read notes its expectation for the watcher
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] k);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    if (!w) begin
      expQ.push_back(d);
      mskQ.push_back(k);
    end
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n == 50) miscompares++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // one character from the receive engine; data lines scrambled afterwards
  task automatic rx(input logic [8:0] c, input logic p, input logic f);
    @(posedge sys_clk);
    rxCharValid <= 1'b1;
    rxChar <= c;
    rxParErr <= p;
    rxFrmErr <= f;
    @(posedge sys_clk);
    rxCharValid <= 1'b0;
    rxChar <= ~c;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watcher takes the oldest note when read data or a character appears
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      m = mskQ.pop_front();
      chk(wb_dat_o & m, expQ.pop_front() & m);
    end
    if (txCharTake === 1'b1 && txCharValid === 1'b1) chk({23'h0, txChar}, {23'h0, txQ.pop_front()});
  end
  // ==========================================
  // main sequence
  initial begin
    i = $urandom(32'h0000_40ed);
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(0, ST, `USC_STA_RESET, AL);
    bus(0, 8'h40, NO, AL);
    $display("test reset done");
    stall <= 1'b1;
    for (i = 0; i < 8; i++) begin
      txQ.push_back(9'($urandom));
      bus(1, TD, {23'h0, txQ[$]}, NO);
      if (i == 0) bus(1, MD, 32'h0000_8000, NO);
      if (i == 0) bus(1, ST, 32'h0000_1400, NO);
    end
    bus(1, TD, B8, NO);
    bus(0, ST, 32'h0000_0200, 32'h0000_0300);
    chk1(txIrq, 1'b0);
    stall <= 1'b0;
    for (i = 0; i < 300 && (txQ.size() > 0 || txBusy !== 1'b0); i++) @(posedge sys_clk);
    bus(0, ST, 32'h0000_0100, 32'h0000_0300);
    chk1(txIrq, 1'b1);
    for (i = 0; i < 4; i++) begin
      bus(1, MD, i[1] ? 32'h0000_9000 : 32'h0000_8000, NO);
      bus(1, ST, i[0] ? 32'h0000_3400 : 32'h0000_1400, NO);
      repeat (3) @(posedge sys_clk);
      chk1(tx_pin_o, i[1] ~^ i[0]);
      chk1(tx_pin_oe, 1'b1);
      chk1(irEnable, i[1]);
    end
    bus(1, MD, 32'h0000_8000, NO);
    bus(1, ST, 32'h0000_1C00, NO);
    repeat (2) @(posedge sys_clk);
    for (i = 0; i < 100 && txBreakReq !== 1'b0; i++) @(posedge sys_clk);
    bus(0, ST, 32'h0000_0100, 32'h0000_0900);
    stall <= 1'b1;
    for (i = 0; i < 3; i++) bus(1, TD, 32'h0000_0055, NO);
    for (i = 0; i < 3; i++) begin
      bus(1, ST, 32'h0000_1400 | (32'(i) << `USC_TXISEL_LSB), NO);
      repeat (2) @(posedge sys_clk);
      chk1(txIrq, i == 0);
    end
    bus(1, ST, 32'h0000_1000, NO);
    bus(0, ST, 32'h0000_0100, 32'h0000_0700);
    chk1(tx_pin_oe, 1'b0);
    stall <= 1'b0;
    $display("test transmit done");
    rx(9'h0A5, 1'b1, 1'b0);
    rx(9'h13C, 1'b0, 1'b1);
    bus(0, ST, 32'h0000_0009, 32'h0000_000D);
    bus(0, RD, 32'h0000_00A5, 32'h0000_00FF);
    bus(0, ST, 32'h0000_0005, 32'h0000_000D);
    bus(0, RD, 32'h0000_003C, 32'h0000_00FF);
    bus(0, ST, NO, 32'h0000_0001);
    rxActive <= 1'b1;
    bus(0, ST, NO, 32'h0000_0010);
    rxActive <= 1'b0;
    for (i = 0; i < 4; i++) rx(9'($urandom), 1'b0, 1'b0);
    for (i = 0; i < 3; i++) begin
      bus(1, ST, 32'h0000_1000 | (32'(i) << 6), NO);
      repeat (2) @(posedge sys_clk);
      chk1(rxIrq, i < 2);
    end
    for (i = 0; i < 5; i++) rx(9'($urandom), 1'b0, 1'b0);
    bus(0, ST, 32'h0000_0003, 32'h0000_0003);
    chk1(rxHold, 1'b1);
    bus(1, ST, 32'h0000_0002, NO);
    bus(0, ST, 32'h0000_0003, 32'h0000_0003);
    bus(1, ST, 32'h0000_1000, NO);
    bus(0, ST, NO, 32'h0000_0003);
    bus(1, MD, 32'h0001_8000, NO);
    for (i = 0; i < 9; i++) rx(9'($urandom), 1'b0, 1'b0);
    bus(0, ST, 32'h0000_0003, 32'h0000_0003);
    chk1(rxHold, 1'b0);
    $display("test receive done");
    bus(1, ST, 32'hFF5A_1020, NO);
    rx(9'h033, 1'b0, 1'b0);
    bus(0, RD, 32'h0000_0033, 32'h0000_00FF);
    bus(1, MD, 32'h0000_8006, NO);
    foreach (adrSeq[j]) rx(adrSeq[j], 1'b0, 1'b0);
    chk({30'h0, parDataSel}, {30'h0, `USC_PDS_NINE});
    bus(0, RD, 32'h0000_015A, B8);
    bus(0, RD, 32'h0000_0077, B8);
    bus(0, ST, NO, 32'h0000_0001);
    bus(1, ST, 32'h005A_1020, NO);
    rx(9'h1C3, 1'b0, 1'b0);
    bus(0, RD, 32'h0000_01C3, B8);
    $display("test address done");
    final_report();
  end
endmodule
bind usc_status_control usc_status_control_properties i_props (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .txAbort, .txCharValid, .txIrq, .rx_pin, .rxLine, .rxPinOwned, .rxHold, .rxFlush,
  .txBreakReq, .txBreakDone);

// ### dv/usc_engine_model.sv
// behavioural frame engine on the far side of the block
`timescale 1ns/100ps
module usc_engine_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic txCharValid,
  input wire logic txBreakReq,
  input wire logic txAbort,
  output logic txCharTake,
  output logic txBusy,
  output logic txBitRaw,
  output logic txBreakDone
);
  int cnt;
  logic brk, arm;
  // mark while idle, low through a break, toggling in a frame
  assign txBitRaw = !txBusy || (!brk && cnt[0]);
  // one frame at a time; stall keeps the buffer full
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      brk <= 1'b0;
      arm <= 1'b1;
      txCharTake <= 1'b0;
      txBusy <= 1'b0;
      txBreakDone <= 1'b0;
    end else begin
      txCharTake <= 1'b0;
      txBreakDone <= 1'b0;
      // rearm only once the request is seen low, else a lagging copy restarts it
      if (!txBreakReq) arm <= 1'b1;
      if (txAbort) begin
        cnt <= 0;
        txBusy <= 1'b0;
        brk <= 1'b0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        txBusy <= 1'b0;
        txBreakDone <= brk;
        brk <= 1'b0;
      end else if (!stall && txBreakReq && arm) begin
        cnt <= 14;
        brk <= 1'b1;
        arm <= 1'b0;
        txBusy <= 1'b1;
      end else if (!stall && txCharValid) begin
        txCharTake <= 1'b1;
        txBusy <= 1'b1;
        cnt <= 3;
      end
    end
  end
endmodule

// ### dv/usc_status_control_properties.sv
// bound assertions on the status and control block ports
`timescale 1ns/100ps
module usc_status_control_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic txAbort,
  input wire logic txCharValid,
  input wire logic txIrq,
  input wire logic rx_pin,
  input wire logic rxLine,
  input wire logic rxPinOwned,
  input wire logic rxHold,
  input wire logic rxFlush,
  input wire logic txBreakReq,
  input wire logic txBreakDone
);
  // ==========================================
  // bus handshake and engine side relations
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_own2;
    rxPinOwned ##1 rxPinOwned;
  endsequence
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_abort;
    txAbort |=> !txCharValid && !txIrq && !txAbort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort left data");
  property p_owned;
    s_own2 |-> rxLine == $past(rx_pin);
  endproperty
  a_owned: assert property (p_owned) else $error("rx line not followed");
  property p_free;
    !rxPinOwned ##1 !rxPinOwned |-> rxLine;
  endproperty
  a_free: assert property (p_free) else $error("rx pin not ignored");
  property p_hold;
    $fell(rxHold) |-> rxFlush;
  endproperty
  a_hold: assert property (p_hold) else $error("hold dropped alone");
  property p_flush;
    rxFlush |=> !rxFlush && !rxHold;
  endproperty
  a_flush: assert property (p_flush) else $error("flush not a pulse");
  property p_brk;
    txBreakReq && txBreakDone && !wb_cyc_i |-> ##[1:2] !txBreakReq;
  endproperty
  a_brk: assert property (p_brk) else $error("break not cleared");
endmodule

// ### hdl/usc_params.svh
// constants for the serial status and control block
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH
// register byte offsets
`define USC_OFS_STA 8'h00
`define USC_OFS_MODE 8'h04
`define USC_OFS_TXD 8'h08
`define USC_OFS_RXD 8'h0C
// status and control field positions
`define USC_MASK_LSB 24
`define USC_ADDR_LSB 16
`define USC_TXISEL_LSB 14
`define USC_TXINV_BIT 13
`define USC_RXEN_BIT 12
`define USC_BRK_BIT 11
`define USC_TXEN_BIT 10
`define USC_TXBF_BIT 9
`define USC_TX_SHIFT_EMPTY_BIT 8
`define USC_RXISEL_LSB 6
`define USC_ADDRESS_DETECT_ENABLE_BIT 5
`define USC_RECEIVER_IDLE_BIT 4
`define USC_PARITY_ERROR_BIT 3
`define USC_FRAMING_ERROR_BIT 2
`define USC_OVERRUN_ERROR_BIT 1
`define USC_RXDA_BIT 0
// mode register field positions
`define USC_ON_BIT 15
`define USC_INFRARED_CODEC_ENABLE_BIT 12
`define USC_PDS_LSB 1
`define USC_RUN_ON_OVERFLOW_BIT 16
// reset values
`define USC_STA_RESET 32'h0000_0110
`define USC_MODE_RESET 32'h0000_0000
// nine data bits, no parity
`define USC_PDS_NINE 2'h3
// buffer depth
`define USC_FIFO_DEPTH 8
`endif

// ### hdl/usc_pkg.sv
// types shared by the serial status and control block
package usc_pkg;
  // interrupt level selects, shared coding for both directions
  typedef enum logic [1:0] {
    USC_SEL_ANY = 2'h0,
    USC_SEL_MID = 2'h1,
    USC_SEL_HIGH = 2'h2,
    USC_SEL_RSVD = 2'h3
  } usc_sel_t;
  // receive buffer entry: errors travel with their character
  typedef struct packed {
    logic parErr;
    logic frmErr;
    logic [8:0] data;
  } usc_rx_entry_t;
endpackage

// ### hdl/usc_status_control.sv
// serial port status and control registers with transmit and receive buffers
// Summary of operation
// - each mask bit chooses whether that address bit is compared; zeros match all
// - with address detect on, the eight-bit match field is the address character
// - tx interrupt: 10 buffer empty, 01 all shifted out, 00 slot free, 11 none
// - infrared off: invert set idles the tx line low, clear idles high
// - infrared on: invert set idles encoded line high, clear idles low
// - receiver enabled and module on owns the rx pin, otherwise pin ignored
// - disabling the receiver releases the pin, keeps buffer and receive flags
// - send break sends start, twelve zeros, stop, then clears itself
// - disabling transmitter aborts, empties buffer, clears flags, releases pin
// - buffer full flag is one when no transmit slot is free
// - shift empty flag is one only when shifter and buffer are empty
// - rx interrupt: 10 three quarters, 01 half, 00 any character, 11 none
// - address detection works only in nine-bit data mode
// - receiver idle reads zero while a character is arriving
// - parity error shows the flag of the character at the buffer head
// - framing error shows the flag of the character at the buffer head
// - overrun set by hardware on overflow, cleared only by software writing zero
// - clearing a set overrun flushes receive buffer and shift register
// - data available reads one while the receive buffer holds a character
// - nine-bit mode is parity and data select code 11
// - run on overflow keeps the shifter running, else it stops accepting
`timescale 1ns/100ps
`include "usc_params.svh"
module usc_status_control #(
  parameter int DEPTH = `USC_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic txCharValid,
  output logic [8:0] txChar,
  input wire logic txCharTake,
  input wire logic txBusy,
  input wire logic txBitRaw,
  input wire logic irEncBit,
  output logic txBreakReq,
  input wire logic txBreakDone,
  output logic txAbort,
  output logic tx_pin_o,
  output logic tx_pin_oe,
  input wire logic rx_pin,
  output logic rxLine,
  output logic rxPinOwned,
  input wire logic rxActive,
  input wire logic rxCharValid,
  input wire logic [8:0] rxChar,
  input wire logic rxParErr,
  input wire logic rxFrmErr,
  output logic rxHold,
  output logic rxFlush,
  output logic txIrq,
  output logic rxIrq,
  output logic irEnable,
  output logic [1:0] parDataSel
);
  import usc_pkg::*;

  localparam int PW = $clog2(DEPTH);

  // ==========================================================
  // elaboration checks
  generate
    if (DEPTH < 4 || (1 << PW) != DEPTH) begin : g_badDepth
      $error("usc_status_control: DEPTH must be a power of two, at least 4");
    end
  endgenerate

  // ==========================================================
  // helpers
  // byte-lane merge, used for the status and mode registers
  function automatic logic [31:0] laneMerge(input logic [31:0] oldV, input logic [31:0] newV,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = oldV;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // bus slave
  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] readMux;
  wire busAcc = wb_cyc_i & wb_stb_i;
  wire commit = busAcc & ack_r; // the edge where the master sees ack
  wire wrCommit = commit & wb_we_i;
  wire hitSta = (wb_adr_i == `USC_OFS_STA);
  wire hitMode = (wb_adr_i == `USC_OFS_MODE);
  wire hitTxd = (wb_adr_i == `USC_OFS_TXD);
  wire hitRxd = (wb_adr_i == `USC_OFS_RXD);

  // one wait cycle, ack held for one cycle only
  // read data is latched on the first edge, so a status bit that moves
  // during the wait cycle is reported with its older value
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= busAcc & ~ack_r;
      if (busAcc & ~ack_r) begin
        rdat_r <= readMux;
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ==========================================================
  // control fields
  logic [7:0] mask_r;
  logic [7:0] matchAddr_r;
  logic [1:0] txSel_r;
  logic [1:0] rxSel_r;
  logic txInv_r, rxEn_r, brk_r, txEn_r, address_detect_enable_r, overrun_error_r;
  logic modOn_r, infrared_codec_enable_r, run_on_overflow_r;
  logic [1:0] pds_r;
  wire [31:0] staNew = laneMerge(readMux, wb_dat_i, wb_sel_i);
  wire staWr = wrCommit & hitSta;
  wire modeWr = wrCommit & hitMode;
  wire [31:0] modeNew = laneMerge(readMux, wb_dat_i, wb_sel_i);
  wire txOff = staWr & txEn_r & ~staNew[`USC_TXEN_BIT];
  wire oerrClr = staWr & overrun_error_r & ~staNew[`USC_OVERRUN_ERROR_BIT];

  // ==========================================================
  // transmit buffer
  logic [8:0] txMem [DEPTH];
  logic [PW-1:0] txWp_r, txRp_r;
  logic [PW:0] txCnt_r;
  wire txFull = (txCnt_r == (PW+1)'(DEPTH));
  wire txEmpty = (txCnt_r == '0);
  wire txPush = wrCommit & hitTxd & ~txFull;
  wire txPop = txCharTake & ~txEmpty & txEn_r;
  wire [PW-1:0] txRpNxt = txPop ? txRp_r + 1'b1 : txRp_r;
  wire [PW:0] txCntNxt = txCnt_r + (PW+1)'(txPush) - (PW+1)'(txPop);
  // a push that becomes the head lands in memory on this same edge, so the
  // head copy is bypassed from the bus or the engine would see a stale slot
  wire txHeadBypass = txPush & (txWp_r == txRpNxt);
  wire [8:0] txHeadNxt = txHeadBypass ? wb_dat_i[8:0] : txMem[txRpNxt];
  wire tx_shift_empty = txEmpty & ~txBusy;

  always_ff @(posedge sys_clk) begin
    if (txPush) begin
      txMem[txWp_r] <= wb_dat_i[8:0];
    end
  end

  // disabling the transmitter flushes the queue
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txWp_r <= '0;
      txRp_r <= '0;
      txCnt_r <= '0;
    end else if (txOff) begin
      txWp_r <= '0;
      txRp_r <= '0;
      txCnt_r <= '0;
    end else begin
      txWp_r <= txPush ? txWp_r + 1'b1 : txWp_r;
      txRp_r <= txRpNxt;
      txCnt_r <= txCntNxt;
    end
  end

  // ==========================================================
  // receive buffer and address filter
  usc_rx_entry_t rxMem [DEPTH];
  logic [PW-1:0] rxWp_r, rxRp_r;
  logic [PW:0] rxCnt_r;
  logic matched_r;
  usc_rx_entry_t rxIn;
  usc_rx_entry_t rxHead;
  wire addrMode = address_detect_enable_r & (pds_r == `USC_PDS_NINE);
  // masked compare with the match field
  wire addrHit = (((rxChar[7:0] ^ matchAddr_r) & mask_r) == 8'h00);
  wire isAddr = rxChar[8];
  // drop data until an address matches
  wire keepChar = ~addrMode | (isAddr ? addrHit : matched_r);
  wire rxFull = (rxCnt_r == (PW+1)'(DEPTH));
  wire rxEmpty = (rxCnt_r == '0);
  wire rxOffer = rxCharValid & keepChar & ~rxHold;
  wire rxPush = rxOffer & ~rxFull;
  wire rxOvf = rxOffer & rxFull;
  wire rxPop = commit & ~wb_we_i & hitRxd & ~rxEmpty;
  assign rxIn = '{parErr: rxParErr, frmErr: rxFrmErr, data: rxChar};
  assign rxHead = rxMem[rxRp_r];

  always_ff @(posedge sys_clk) begin
    if (rxPush) begin
      rxMem[rxWp_r] <= rxIn;
    end
  end

  // clearing overrun empties the buffer
  // a character arriving on the flushing edge is lost along with the rest
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxWp_r <= '0;
      rxRp_r <= '0;
      rxCnt_r <= '0;
    end else if (oerrClr & ~rxOvf) begin
      rxWp_r <= '0;
      rxRp_r <= '0;
      rxCnt_r <= '0;
    end else begin
      rxWp_r <= rxPush ? rxWp_r + 1'b1 : rxWp_r;
      rxRp_r <= rxPop ? rxRp_r + 1'b1 : rxRp_r;
      rxCnt_r <= rxCnt_r + (PW+1)'(rxPush) - (PW+1)'(rxPop);
    end
  end

  // address match memory, leaving address mode forgets it
  // data seen before any matching address is always dropped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      matched_r <= 1'b0;
    end else if (~addrMode) begin
      matched_r <= 1'b0;
    end else if (rxCharValid & isAddr) begin
      matched_r <= addrHit;
    end
  end

  // ==========================================================
  // register writes and hardware-owned bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= 8'h00;
      matchAddr_r <= 8'h00;
      txSel_r <= 2'h0;
      rxSel_r <= 2'h0;
      txInv_r <= 1'b0;
      rxEn_r <= 1'b0;
      brk_r <= 1'b0;
      txEn_r <= 1'b0;
      address_detect_enable_r <= 1'b0;
      overrun_error_r <= 1'b0;
      modOn_r <= 1'b0;
      infrared_codec_enable_r <= 1'b0;
      run_on_overflow_r <= 1'b0;
      pds_r <= 2'h0;
    end else begin
      if (staWr) begin
        mask_r <= staNew[`USC_MASK_LSB +: 8];
        matchAddr_r <= staNew[`USC_ADDR_LSB +: 8];
        txSel_r <= staNew[`USC_TXISEL_LSB +: 2];
        rxSel_r <= staNew[`USC_RXISEL_LSB +: 2];
        txInv_r <= staNew[`USC_TXINV_BIT];
        rxEn_r <= staNew[`USC_RXEN_BIT];
        txEn_r <= staNew[`USC_TXEN_BIT];
        address_detect_enable_r <= staNew[`USC_ADDRESS_DETECT_ENABLE_BIT];
      end
      // break self-clears when its frame ends; a fresh set wins
      if (staWr & staNew[`USC_BRK_BIT] & ~txOff) begin
        brk_r <= 1'b1;
      end else if (txBreakDone | txOff | (staWr & ~staNew[`USC_BRK_BIT])) begin
        brk_r <= 1'b0;
      end
      // overflow sets, only software clears, set wins
      if (rxOvf) begin
        overrun_error_r <= 1'b1;
      end else if (oerrClr) begin
        overrun_error_r <= 1'b0;
      end
      if (modeWr) begin
        modOn_r <= modeNew[`USC_ON_BIT];
        infrared_codec_enable_r <= modeNew[`USC_INFRARED_CODEC_ENABLE_BIT];
        pds_r <= modeNew[`USC_PDS_LSB +: 2];
        run_on_overflow_r <= modeNew[`USC_RUN_ON_OVERFLOW_BIT];
      end
    end
  end

  // ==========================================================
  // read decode
  wire txOwn = txEn_r & modOn_r;
  wire rxOwn = rxEn_r & modOn_r;
  wire [31:0] staRd = {mask_r, matchAddr_r, txSel_r, txInv_r, rxEn_r, brk_r, txEn_r,
                       txFull, tx_shift_empty, rxSel_r, address_detect_enable_r,
                       ~(rxOwn & rxActive), // idle flag
                       ~rxEmpty & rxHead.parErr, // head parity
                       ~rxEmpty & rxHead.frmErr, // head framing
                       overrun_error_r,
                       ~rxEmpty}; // data available
  wire [31:0] modeRd = {15'h0000, run_on_overflow_r, modOn_r, 2'h0, infrared_codec_enable_r, 9'h000, pds_r, 1'b0};
  wire [31:0] rxdRd = {23'h00_0000, rxEmpty ? 9'h000 : rxHead.data};
  // unmapped offsets read zero and drop writes
  assign readMux = hitSta ? staRd : hitMode ? modeRd : hitRxd ? rxdRd : 32'h0000_0000;

  // ==========================================================
  // interrupt levels
  // tx levels are judged on the next count so they move with the write itself
  logic txIrqNxt, rxIrqNxt;
  always_comb begin
    case (usc_sel_t'(txSel_r))
      USC_SEL_HIGH: txIrqNxt = (txCntNxt == '0);
      USC_SEL_MID: txIrqNxt = (txCntNxt == '0) & ~txBusy;
      USC_SEL_ANY: txIrqNxt = (txCntNxt != (PW+1)'(DEPTH));
      default: txIrqNxt = 1'b0;
    endcase
    // rx level select, thresholds from depth
    case (usc_sel_t'(rxSel_r))
      USC_SEL_HIGH: rxIrqNxt = (rxCnt_r >= (PW+1)'(DEPTH * 3 / 4));
      USC_SEL_MID: rxIrqNxt = (rxCnt_r >= (PW+1)'(DEPTH / 2));
      USC_SEL_ANY: rxIrqNxt = ~rxEmpty;
      default: rxIrqNxt = 1'b0;
    endcase
  end

  // ==========================================================
  // pins and engine outputs, all registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txCharValid <= 1'b0;
      txChar <= 9'h000;
      txBreakReq <= 1'b0;
      txAbort <= 1'b0;
      tx_pin_o <= 1'b1;
      tx_pin_oe <= 1'b0;
      rxLine <= 1'b1;
      rxPinOwned <= 1'b0;
      rxHold <= 1'b0;
      rxFlush <= 1'b0;
      txIrq <= 1'b0;
      rxIrq <= 1'b0;
      irEnable <= 1'b0;
      parDataSel <= 2'h0;
    end else begin
      // valid and head track the next pointer so a take never repeats
      txCharValid <= (txCntNxt != '0) & ~txOff & txEn_r;
      txChar <= txHeadNxt;
      txBreakReq <= brk_r;
      txAbort <= txOff;
      // idle level follows invert, per encoding
      tx_pin_o <= infrared_codec_enable_r ? (irEncBit ^ txInv_r) : (txBitRaw ^ txInv_r);
      tx_pin_oe <= txOwn & ~txOff;
      // an unowned line rests at mark so the engine never sees a start bit
      // pin ignored unless enabled and on
      rxLine <= rxOwn ? rx_pin : 1'b1;
      rxPinOwned <= rxOwn;
      // stop accepting on overrun unless told to run
      rxHold <= (overrun_error_r | rxOvf) & ~run_on_overflow_r & ~(oerrClr & ~rxOvf);
      rxFlush <= oerrClr & ~rxOvf;
      txIrq <= txIrqNxt & txEn_r;
      rxIrq <= rxIrqNxt;
      irEnable <= infrared_codec_enable_r;
      parDataSel <= pds_r;
    end
  end
endmodule
